/* File: hw/dcc_top.sv */
// dual comparator control: registers, port 0 input gating, timing, irq
module dcc_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // analog comparator decisions
  input wire logic [1:0] cmp_raw_in,
  // port 0 pin levels
  input wire logic [7:0] port0_pins_in,
  // power reduction state of the cpu
  input wire logic idle_in,
  input wire logic power_down_in,
  // analog front end control
  output logic [1:0] cmp_enable_out,
  output logic [1:0] positive_input_select_out,
  output logic [1:0] negative_input_select_out,
  output logic [7:0] port0_input_off_out,
  // comparator output pins
  output logic [1:0] cmp_pin_out,
  output logic [1:0] cmp_pin_oe_out,
  // port 0 digital value after gating
  output logic [7:0] port0_digital_out,
  // cpu timing and interrupt
  output logic machine_cycle_out,
  output logic cmp_irq_out,
  output logic wake_out
);
  // per-comparator control bits: enable, positive, negative, output enable
  logic [1:0] en_ff;
  logic [1:0] pos_sel_ff;
  logic [1:0] neg_sel_ff;
  logic [1:0] oe_ff;
  logic [1:0] flag_clr_ff;
  logic [7:0] port0_analog_input_disable_ff;
  logic global_irq_enable_ff;
  logic [1:0] comparator_irq_enable_ff;
  logic standard_timing_option_ff;
  logic [7:0] cpu_clock_divider_ff;
  logic [7:0] rdata_ff;
  logic [7:0] port0_ff;
  logic [1:0] pin_ff;
  logic [1:0] pin_oe_ff;
  logic irq_ff;
  logic wake_ff;
  logic [3:0] osc_cnt_ff;
  logic [7:0] div_cnt_ff;
  logic mc_ff;

  logic [1:0] result;
  logic [1:0] flag;
  logic [1:0] settling;
  logic wr_cmp_one;
  logic wr_cmp_two;
  logic [3:0] mc_last;
  logic [1:0] irq_req;
  logic [7:0] port0_gated;

  dcc_chan_if chan_bus [2] ();

  // one channel per comparator, identical hardware behind each register
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    assign chan_bus[i].en = en_ff[i];
    assign chan_bus[i].flag_clr = flag_clr_ff[i];
    assign result[i] = chan_bus[i].result;
    assign flag[i] = chan_bus[i].flag;
    assign settling[i] = chan_bus[i].settling;

    dcc_comp_chan u_chan (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .cmp_raw_in(cmp_raw_in[i]),
      .bus(chan_bus[i].chan)
    );
  end

  // write decode for the two control registers
  assign wr_cmp_one = reg_wr_in && (reg_addr_in == dcc_pkg::OFS_CMP_ONE);
  assign wr_cmp_two = reg_wr_in && (reg_addr_in == dcc_pkg::OFS_CMP_TWO);

  // control bits of both comparators, same layout in each register
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      en_ff <= 2'h0;
      pos_sel_ff <= 2'h0;
      neg_sel_ff <= 2'h0;
      oe_ff <= 2'h0;
    end
    else
    begin
      if (wr_cmp_one)
      begin
        en_ff[0] <= reg_wdata_in[dcc_pkg::CTL_EN];
        pos_sel_ff[0] <= reg_wdata_in[dcc_pkg::CTL_POS];
        neg_sel_ff[0] <= reg_wdata_in[dcc_pkg::CTL_NEG];
        oe_ff[0] <= reg_wdata_in[dcc_pkg::CTL_OE];
      end
      if (wr_cmp_two)
      begin
        en_ff[1] <= reg_wdata_in[dcc_pkg::CTL_EN];
        pos_sel_ff[1] <= reg_wdata_in[dcc_pkg::CTL_POS];
        neg_sel_ff[1] <= reg_wdata_in[dcc_pkg::CTL_NEG];
        oe_ff[1] <= reg_wdata_in[dcc_pkg::CTL_OE];
      end
    end
  end

  // writing zero to the flag bit clears it; writing one leaves it alone,
  // so read-modify-write code cannot clear a flag that it read as set
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      flag_clr_ff <= 2'h0;
    else
    begin
      flag_clr_ff[0] <= wr_cmp_one && !reg_wdata_in[dcc_pkg::CTL_FLAG];
      flag_clr_ff[1] <= wr_cmp_two && !reg_wdata_in[dcc_pkg::CTL_FLAG];
    end
  end

  // port 0 digital input disable register
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      port0_analog_input_disable_ff <= dcc_pkg::RST_BYTE;
    else if (reg_wr_in && (reg_addr_in == dcc_pkg::OFS_PT0_DIS))
      port0_analog_input_disable_ff <= reg_wdata_in;
  end

  // interrupt enables: global plus one per comparator
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      global_irq_enable_ff <= 1'b0;
      comparator_irq_enable_ff <= 2'h0;
    end
    else if (reg_wr_in && (reg_addr_in == dcc_pkg::OFS_IRQ_EN))
    begin
      global_irq_enable_ff <= reg_wdata_in[dcc_pkg::IEN_GLOBAL];
      comparator_irq_enable_ff[0] <= reg_wdata_in[dcc_pkg::IEN_CMP_ONE];
      comparator_irq_enable_ff[1] <= reg_wdata_in[dcc_pkg::IEN_CMP_TWO];
    end
  end

  // timing option and cpu clock divider
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      standard_timing_option_ff <= 1'b0;
      cpu_clock_divider_ff <= dcc_pkg::RST_BYTE;
    end
    else
    begin
      if (reg_wr_in && (reg_addr_in == dcc_pkg::OFS_TIMING))
        standard_timing_option_ff <= reg_wdata_in[dcc_pkg::TIM_STD];
      if (reg_wr_in && (reg_addr_in == dcc_pkg::OFS_CLK_DIV))
        cpu_clock_divider_ff <= reg_wdata_in;
    end
  end

  // machine cycle length picked by the timing option
  assign mc_last = (standard_timing_option_ff ? dcc_pkg::MC_STD
                    : dcc_pkg::MC_FAST) - 4'h1;

  // oscillator clocks per machine cycle, then the divider stretches it;
  // a shorter length written mid-cycle takes effect at once, no stall
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      osc_cnt_ff <= dcc_pkg::RST_CTL;
      div_cnt_ff <= dcc_pkg::RST_BYTE;
      mc_ff <= 1'b0;
    end
    else
    begin
      mc_ff <= 1'b0;
      if (osc_cnt_ff >= mc_last)
      begin
        osc_cnt_ff <= 4'h0;
        if (div_cnt_ff >= cpu_clock_divider_ff)
        begin
          div_cnt_ff <= 8'h00;
          mc_ff <= 1'b1;
        end
        else
          div_cnt_ff <= div_cnt_ff + 8'h01;
      end
      else
        osc_cnt_ff <= osc_cnt_ff + 4'h1;
    end
  end

  // disabled pins read as zero regardless of their voltage
  assign port0_gated = port0_pins_in & ~port0_analog_input_disable_ff;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      port0_ff <= dcc_pkg::RST_BYTE;
    else
      port0_ff <= port0_gated;
  end

  // comparator result to its pin when the output enable is set;
  // the pin is only driven while the comparator itself is on
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pin_ff <= 2'h0;
      pin_oe_ff <= 2'h0;
    end
    else
    begin
      pin_ff <= result;
      pin_oe_ff <= oe_ff & en_ff;
    end
  end

  // request needs flag, its own enable and the global enable
  assign irq_req = flag & comparator_irq_enable_ff
                   & {2{global_irq_enable_ff}};

  // the flag stays set after the request is taken, so the line holds
  // until the service routine clears it
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      irq_ff <= 1'b0;
    else
      irq_ff <= |irq_req;
  end

  // wake only from idle or power down; irq itself is not gated by mode
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      wake_ff <= 1'b0;
    else
      wake_ff <= (|irq_req) && (idle_in || power_down_in);
  end

  // read data, valid in the cycle after the read strobe only
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      rdata_ff <= dcc_pkg::RST_BYTE;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        dcc_pkg::OFS_CMP_ONE:
        begin
          rdata_ff <= 8'h00;
          rdata_ff[dcc_pkg::CTL_EN] <= en_ff[0];
          rdata_ff[dcc_pkg::CTL_POS] <= pos_sel_ff[0];
          rdata_ff[dcc_pkg::CTL_NEG] <= neg_sel_ff[0];
          rdata_ff[dcc_pkg::CTL_OE] <= oe_ff[0];
          rdata_ff[dcc_pkg::CTL_OUT] <= result[0];
          rdata_ff[dcc_pkg::CTL_FLAG] <= flag[0];
        end
        dcc_pkg::OFS_CMP_TWO:
        begin
          rdata_ff <= 8'h00;
          rdata_ff[dcc_pkg::CTL_EN] <= en_ff[1];
          rdata_ff[dcc_pkg::CTL_POS] <= pos_sel_ff[1];
          rdata_ff[dcc_pkg::CTL_NEG] <= neg_sel_ff[1];
          rdata_ff[dcc_pkg::CTL_OE] <= oe_ff[1];
          rdata_ff[dcc_pkg::CTL_OUT] <= result[1];
          rdata_ff[dcc_pkg::CTL_FLAG] <= flag[1];
        end
        dcc_pkg::OFS_PT0_DIS:
          rdata_ff <= port0_analog_input_disable_ff;
        dcc_pkg::OFS_IRQ_EN:
        begin
          rdata_ff <= 8'h00;
          rdata_ff[dcc_pkg::IEN_GLOBAL] <= global_irq_enable_ff;
          rdata_ff[dcc_pkg::IEN_CMP_ONE] <= comparator_irq_enable_ff[0];
          rdata_ff[dcc_pkg::IEN_CMP_TWO] <= comparator_irq_enable_ff[1];
        end
        dcc_pkg::OFS_TIMING:
        begin
          rdata_ff <= 8'h00;
          rdata_ff[dcc_pkg::TIM_STD] <= standard_timing_option_ff;
        end
        dcc_pkg::OFS_CLK_DIV:
          rdata_ff <= cpu_clock_divider_ff;
        dcc_pkg::OFS_STATUS:
        begin
          rdata_ff <= 8'h00;
          rdata_ff[dcc_pkg::STS_IDLE] <= idle_in;
          rdata_ff[dcc_pkg::STS_PD] <= power_down_in;
          rdata_ff[dcc_pkg::STS_SETTLE] <= settling[0];
          rdata_ff[dcc_pkg::STS_SETTLE + 1] <= settling[1];
        end
        dcc_pkg::OFS_PORT0:
          rdata_ff <= port0_gated;
        default:
          rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end

  // outputs straight from registers
  assign reg_rdata_out = rdata_ff;
  assign cmp_enable_out = en_ff;
  assign positive_input_select_out = pos_sel_ff;
  assign negative_input_select_out = neg_sel_ff;
  assign port0_input_off_out = port0_analog_input_disable_ff;
  assign cmp_pin_out = pin_ff;
  assign cmp_pin_oe_out = pin_oe_ff;
  assign port0_digital_out = port0_ff;
  assign machine_cycle_out = mc_ff;
  assign cmp_irq_out = irq_ff;
  assign wake_out = wake_ff;
endmodule

/* File: hw/dcc_pkg.sv */
// constants shared by the dual comparator control block
package dcc_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] OFS_CMP_ONE = 8'h00;
  localparam logic [7:0] OFS_CMP_TWO = 8'h01;
  localparam logic [7:0] OFS_PT0_DIS = 8'h02;
  localparam logic [7:0] OFS_IRQ_EN = 8'h03;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_CLK_DIV = 8'h05;
  localparam logic [7:0] OFS_STATUS = 8'h06;
  localparam logic [7:0] OFS_PORT0 = 8'h07;

  // comparator control register fields
  localparam int CTL_EN = 5;
  localparam int CTL_POS = 4;
  localparam int CTL_NEG = 3;
  localparam int CTL_OE = 2;
  localparam int CTL_OUT = 1;
  localparam int CTL_FLAG = 0;

  // interrupt enable register fields
  localparam int IEN_GLOBAL = 7;
  localparam int IEN_CMP_ONE = 0;
  localparam int IEN_CMP_TWO = 1;

  // timing register field
  localparam int TIM_STD = 0;

  // status register fields
  localparam int STS_IDLE = 0;
  localparam int STS_PD = 1;
  localparam int STS_SETTLE = 2;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CTL = 4'h0;

  // machine cycle lengths in oscillator cycles
  localparam logic [3:0] MC_FAST = 4'h6;
  localparam logic [3:0] MC_STD = 4'hC;

  // comparator start-up time and its length in clocks
  localparam int CLK_HZ = 40000000;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000));
  localparam logic [8:0] SETTLE_LAST = 9'(SETTLE_CYC - 1);
endpackage

/* File: hw/dcc_chan_if.sv */
// control and status carried between the top and one comparator channel
interface dcc_chan_if;
  logic en;
  logic flag_clr;
  logic result;
  logic flag;
  logic settling;
  modport ctrl (output en, output flag_clr,
                input result, input flag, input settling);
  modport chan (input en, input flag_clr,
                output result, output flag, output settling);
endinterface

/* File: hw/dcc_comp_chan.sv */
// one comparator channel: synchroniser, change detect, flag, settle timer
module dcc_comp_chan (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // decision from the analog comparator
  input wire logic cmp_raw_in,
  // control and status toward the top
  dcc_chan_if.chan bus
);
  logic meta_ff;
  logic sync_ff;
  logic flag_ff;
  logic [8:0] settle_ff;
  logic en_d_ff;
  logic hist_ff;

  // two stages, only the second is looked at downstream
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      hist_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= cmp_raw_in & bus.en;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  // runs in idle and power down alike, no gating by mode
  // a change sets the flag; set beats a same-cycle clear
  // the first stage may be metastable, so compare the second with history
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      flag_ff <= 1'b0;
    else if (bus.en && (sync_ff != hist_ff))
      flag_ff <= 1'b1;
    else if (bus.flag_clr)
      flag_ff <= 1'b0;
  end

  // start-up window after enable; hardware only reports it
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      en_d_ff <= 1'b0;
      settle_ff <= 9'h000;
    end
    else
    begin
      en_d_ff <= bus.en;
      if (bus.en && !en_d_ff)
        settle_ff <= dcc_pkg::SETTLE_LAST;
      else if (!bus.en)
        settle_ff <= 9'h000;
      else if (settle_ff != 9'h000)
        settle_ff <= settle_ff - 9'h001;
    end
  end

  assign bus.result = sync_ff;
  assign bus.flag = flag_ff;
  assign bus.settling = (settle_ff != 9'h000) || (bus.en && !en_d_ff);
endmodule

/* File: bench/dcc_check_sva.sv */
// port checker for the dual comparator control block
module dcc_check_sva (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // watched ports
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [1:0] cmp_raw_in,
  input wire logic [7:0] port0_pins_in,
  input wire logic idle_in,
  input wire logic power_down_in,
  input wire logic [1:0] cmp_enable_out,
  input wire logic [7:0] port0_input_off_out,
  input wire logic [1:0] cmp_pin_out,
  input wire logic [1:0] cmp_pin_oe_out,
  input wire logic [7:0] port0_digital_out,
  input wire logic machine_cycle_out,
  input wire logic cmp_irq_out,
  input wire logic wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // five clocks of a steady decision cover both synchroniser stages
  sequence steady_one;
    (cmp_enable_out[0] && $stable(cmp_raw_in[0])) [*5];
  endsequence
  sequence steady_two_pd;
    (power_down_in && cmp_enable_out[1] && $stable(cmp_raw_in[1])) [*5];
  endsequence
  AST_P0_GATE: assert property (
    !$past(reset_in) |-> port0_digital_out ==
      ($past(port0_pins_in) & ~$past(port0_input_off_out)))
    else $error("port 0 gated value wrong");
  AST_P0_OFF: assert property (
    (port0_digital_out & $past(port0_input_off_out)) == 8'h00)
    else $error("disabled port 0 bit reads one");
  AST_CMP_SYNC: assert property (
    steady_one |-> cmp_pin_out[0] == cmp_raw_in[0])
    else $error("comparator one result does not follow");
  AST_PD_KEEP: assert property (
    steady_two_pd |-> cmp_pin_out[1] == cmp_raw_in[1])
    else $error("comparator two stalls in power down");
  AST_OE_GATE: assert property (
    cmp_pin_oe_out[1] |-> cmp_enable_out[1] || $past(cmp_enable_out[1]))
    else $error("pin driven by a disabled comparator");
  AST_WAKE_SRC: assert property (
    wake_out |-> $past(idle_in) || $past(power_down_in))
    else $error("wake outside power reduction");
  AST_MC_GAP: assert property (
    machine_cycle_out |=> !machine_cycle_out [*5])
    else $error("machine cycle shorter than six clocks");
  AST_RD_DATA: assert property (
    reg_rdata_out != 8'h00 |-> $past(reg_rd_in))
    else $error("read data without a read");
endmodule

/* File: bench/dcc_analog_model.sv */
// analog front end model: two comparators fed by test voltages in mV
module dcc_analog_model #(
  parameter logic [15:0] VREF_MV = 16'h0500
) (
  // selects from the block
  input wire logic [1:0] enable_in,
  input wire logic [1:0] pos_sel_in,
  input wire logic [1:0] neg_sel_in,
  // pin voltages, shared by both comparators to keep the bench small
  input wire logic [15:0] pos_a_mv_in,
  input wire logic [15:0] pos_b_mv_in,
  input wire logic [15:0] neg_pin_mv_in,
  // decisions
  output logic [1:0] decision_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // one only while positive exceeds negative; a switched-off part gives 0
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      decision_out[i] = enable_in[i] &&
        ((pos_sel_in[i] ? pos_b_mv_in : pos_a_mv_in) >
         (neg_sel_in[i] ? VREF_MV : neg_pin_mv_in));
    end
  end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the dual comparator control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] port0_pins_in = 8'hA5;
  logic idle_in = 1'b0;
  logic power_down_in = 1'b0;
  logic [15:0] pos_a = 16'h07D0; // 2000 mV
  logic [15:0] pos_b = 16'h044C; // 1100 mV, between pin and reference
  logic [7:0] reg_rdata_out, port0_input_off_out, port0_digital_out;
  logic [1:0] cmp_raw_in, cmp_enable_out, cmp_pin_out, cmp_pin_oe_out;
  logic [1:0] positive_input_select_out, negative_input_select_out;
  logic machine_cycle_out, cmp_irq_out, wake_out, res;
  logic [2:0] k;
  int fail_count = 0;
  int total_checks = 0;
  int ch;
  always #12.5 clk_in = ~clk_in;
  dcc_top dcc_top_i (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cmp_raw_in, .port0_pins_in,
    .idle_in, .power_down_in, .cmp_enable_out, .positive_input_select_out,
    .negative_input_select_out, .port0_input_off_out, .cmp_pin_out,
    .cmp_pin_oe_out, .port0_digital_out, .machine_cycle_out, .cmp_irq_out,
    .wake_out);
  dcc_analog_model dcc_analog_model_i (.enable_in(cmp_enable_out),
    .pos_sel_in(positive_input_select_out),
    .neg_sel_in(negative_input_select_out), .pos_a_mv_in(pos_a),
    .pos_b_mv_in(pos_b), .neg_pin_mv_in(16'h03E8),
    .decision_out(cmp_raw_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, m, exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out & m, exp);
  endtask
  // second full period is measured, the first may straddle a change
  task automatic gap(input logic [7:0] exp);
    int n;
    for (int p = 0; p < 2; p++)
    begin
      n = 0;
      do
      begin
        cyc(1);
        n++;
      end
      while (machine_cycle_out !== 1'b1 && n < 300);
    end
    chk(8'(n), exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    // reset values, with address 08 unmapped
    for (int a = 0; a < 9; a++)
      rd(8'(a), 8'hFF, (a == 7) ? 8'hA5 : 8'h00);
    $display("test reset values done");
    wr(dcc_pkg::OFS_PT0_DIS, 8'h30);
    rd(dcc_pkg::OFS_PORT0, 8'hFF, 8'h85);
    @(posedge clk_in);
    port0_pins_in <= 8'hFF;
    cyc(2);
    chk(port0_digital_out, 8'hCF);
    chk(port0_input_off_out, 8'h30);
    $display("test port 0 gating done");
    // all eight set-ups on both comparators
    for (int c = 0; c < 16; c++)
    begin
      k = 3'(c);
      ch = c / 8;
      res = !(k[2] && k[1]);
      wr(8'(ch), {3'b001, k, 2'b00});
      cyc(6);
      rd(8'(ch), 8'hFE, {3'b001, k, res, 1'b0});
      chk({positive_input_select_out[ch], negative_input_select_out[ch]},
        {6'h00, k[2], k[1]});
      chk({cmp_pin_oe_out[ch], cmp_pin_out[ch]}, {6'h00, k[0], res});
      chk({6'h00, cmp_enable_out}, {6'h00, c >= 8, 1'b1});
      // start-up window reported right after each comparator is turned on
      if (c % 8 == 0)
        rd(dcc_pkg::OFS_STATUS, 8'h0C, (c == 0) ? 8'h04 : 8'h0C);
    end
    $display("test configurations done");
    // flag cleared after the set-up settles, before the enables
    wr(dcc_pkg::OFS_CMP_ONE, 8'h20);
    cyc(6);
    wr(dcc_pkg::OFS_CMP_ONE, 8'h20);
    cyc(2);
    rd(dcc_pkg::OFS_CMP_ONE, 8'hFF, 8'h22);
    // software keeps the irq off until both start-up windows are over
    cyc(400);
    rd(dcc_pkg::OFS_STATUS, 8'h0C, 8'h00);
    wr(dcc_pkg::OFS_IRQ_EN, 8'h01);
    pos_a <= 16'h0064;
    cyc(6);
    rd(dcc_pkg::OFS_CMP_ONE, 8'hFF, 8'h21);
    chk({cmp_irq_out, wake_out}, 8'h00);
    @(posedge clk_in);
    idle_in <= 1'b1;
    wr(dcc_pkg::OFS_IRQ_EN, 8'h81);
    cyc(4);
    chk({cmp_irq_out, wake_out}, 8'h03);
    wr(dcc_pkg::OFS_IRQ_EN, 8'h80);
    cyc(4);
    chk({cmp_irq_out, wake_out}, 8'h00);
    wr(dcc_pkg::OFS_IRQ_EN, 8'h81);
    cyc(4);
    chk({cmp_irq_out, wake_out}, 8'h03);
    @(posedge clk_in);
    idle_in <= 1'b0;
    power_down_in <= 1'b1;
    wr(dcc_pkg::OFS_CMP_ONE, 8'h20);
    cyc(4);
    chk({cmp_irq_out, wake_out}, 8'h00);
    @(posedge clk_in);
    pos_a <= 16'h07D0;
    cyc(6);
    chk({cmp_irq_out, wake_out}, 8'h03);
    @(posedge clk_in);
    power_down_in <= 1'b0;
    $display("test change flag and interrupt done");
    gap(8'h06);
    wr(dcc_pkg::OFS_TIMING, 8'h01);
    gap(8'h0C);
    wr(dcc_pkg::OFS_CLK_DIV, 8'h01);
    gap(8'h18);
    $display("test machine cycle done");
    finish_test();
  end
  // watchdog: the tests need well under 2000 clocks
  initial
  begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
bind dcc_top dcc_check_sva dcc_check_sva_i (.clk_in, .reset_in, .reg_rd_in,
  .reg_rdata_out, .cmp_raw_in, .port0_pins_in, .idle_in, .power_down_in,
  .cmp_enable_out, .port0_input_off_out, .cmp_pin_out, .cmp_pin_oe_out,
  .port0_digital_out, .machine_cycle_out, .cmp_irq_out, .wake_out);
